// File: pkg/pccr_params.svh
`ifndef PCCR_PARAMS_SVH
`define PCCR_PARAMS_SVH
// Operation
// - Each register decoded at a fixed word offset, control lowest, input select highest.
// - Flag-set register: ones set matching flags, zeros leave them alone.
// - Flag-clear register: ones clear matching flags, zeros leave them alone.
// - Limit value read-only; software changes it through the limit buffer.
// - Secondary count writable by software and also advanced by hardware.
// - Control register lives in counter domain; writes except the hold bit cross on counter ticks.
// - Two-bit field picks one of four event channels as trigger.
// - Polarity 0 triggers on rising edge, 1 on falling edge.
// - Gate enable blocks counter clock while channel level equals inverse polarity.
// - Compare mode 0 matches when count is at or below limit.
// - Compare mode 1 matches when count is at or above limit.
// - Compare mode 2 matches inside limit lower byte to upper byte.
// - Slow-clock trigger every 1, 2 or 4 cycles for prescale 0..2.
// - Prescale code 3 triggers every eighth slow clock cycle.
// - Trigger mode: 0 off, 1 prescaled slow clock, 2 event edge.
// - Match sets compare flag, event output held until next event; counter cleared.
// - Hold bit resets counter domain; release two counter ticks after clear.

// Register byte offsets
`define PCCR_OFF_CTRL      6'h00
`define PCCR_OFF_CMD       6'h04
`define PCCR_OFF_STATE     6'h08
`define PCCR_OFF_COUNT     6'h0c
`define PCCR_OFF_LIMIT     6'h10
`define PCCR_OFF_LIMIT_BUF 6'h14
`define PCCR_OFF_FLAGS     6'h18
`define PCCR_OFF_FLAG_SET  6'h1c
`define PCCR_OFF_FLAG_CLR  6'h20
`define PCCR_OFF_IEN       6'h24
`define PCCR_OFF_ROUTE     6'h28
`define PCCR_OFF_FREEZE    6'h2c
`define PCCR_OFF_SYNC      6'h30
`define PCCR_OFF_SEC_COUNT 6'h38
`define PCCR_OFF_INPUT     6'h3c

// Control fields and reset values
`define PCCR_CTRL_MASK     32'h7ecccf7f
`define PCCR_CTRL_RESET    32'h00000000
`define PCCR_PLAIN_MASK    32'h0000ffff
`define PCCR_F_SEL_HI      30
`define PCCR_F_SEL_LO      29
`define PCCR_F_POL         28
`define PCCR_F_GATE        27
`define PCCR_F_CMP_HI      26
`define PCCR_F_CMP_LO      25
`define PCCR_F_PRESC_HI    23
`define PCCR_F_PRESC_LO    22
`define PCCR_F_MODE_HI     19
`define PCCR_F_MODE_LO     18
`define PCCR_F_HOLD        5

// Flags, commands, pending bits
`define PCCR_FLAG_MASK     6'h3f
`define PCCR_FLAG_OVF      1
`define PCCR_FLAG_SEC_OVF  4
`define PCCR_FLAG_CMP      5
`define PCCR_CMD_CLEAR     0
`define PCCR_CMD_LOAD      1
`define PCCR_PEND_CTRL     0
`define PCCR_PEND_CMD      1
`define PCCR_PEND_LIMB     2
`define PCCR_PEND_SEC      3
`define PCCR_RELEASE_TICKS 2'h2
`endif

// File: pkg/pccr_pkg.sv
package pccr_pkg;
    typedef enum logic [1:0] {
        PCCR_TRIG_OFF   = 2'b00,
        PCCR_TRIG_SLOW  = 2'b01,
        PCCR_TRIG_EVENT = 2'b10,
        PCCR_TRIG_RSVD  = 2'b11
    } pccr_trig_mode_t;

    typedef enum logic [1:0] {
        PCCR_CMP_AT_OR_BELOW = 2'b00,
        PCCR_CMP_AT_OR_ABOVE = 2'b01,
        PCCR_CMP_RANGE       = 2'b10,
        PCCR_CMP_RSVD        = 2'b11
    } pccr_cmp_mode_t;
endpackage

// File: rtl/pccr_core.sv
`timescale 1ns/10ps
`include "pccr_params.svh"
module pccr_core
    import pccr_pkg::*;
#(
    parameter int              CNT_W       = 16,
    parameter logic [CNT_W-1:0] LIMIT_RESET = 16'h00ff
) (
    input  wire logic        sys_clk_in,
    input  wire logic        rstn_in,
    input  wire logic [5:0]  addr_in,
    input  wire logic [31:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic      [31:0] rdata_out,
    input  wire logic        slow_tick_in,
    input  wire logic        count_pulse_in,
    input  wire logic [3:0]  event_chan_in,
    output logic             cce_event_out
);

    // ****************************************
    // State
    // ****************************************
    logic [31:0]      ctrl_shadow;
    logic [31:0]      ctrl_act;
    logic [CNT_W-1:0] limit_buf;
    logic [CNT_W-1:0] limit_val;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] sec_count;
    logic [CNT_W-1:0] sec_wdata;
    logic [5:0]       flags;
    logic [5:0]       ien;
    logic [15:0]      route;
    logic [15:0]      insel;
    logic             freeze;
    logic [3:0]       pend;
    logic [1:0]       cmd_stage;
    logic [1:0]       rel_cnt;
    logic [2:0]       presc_cnt;
    logic [3:0]       ev_prev;

    logic [31:0]      next_ctrl_shadow;
    logic [31:0]      next_ctrl_act;
    logic [CNT_W-1:0] next_limit_buf;
    logic [CNT_W-1:0] next_limit_val;
    logic [CNT_W-1:0] next_count;
    logic [CNT_W-1:0] next_sec_count;
    logic [CNT_W-1:0] next_sec_wdata;
    logic [5:0]       next_flags;
    logic [5:0]       next_ien;
    logic [15:0]      next_route;
    logic [15:0]      next_insel;
    logic             next_freeze;
    logic [3:0]       next_pend;
    logic [1:0]       next_cmd_stage;
    logic [1:0]       next_rel_cnt;
    logic [2:0]       next_presc_cnt;
    logic             next_cce_event;
    logic [31:0]      next_rdata;

    // ****************************************
    // Trigger decode
    // ****************************************
    pccr_trig_mode_t  trig_mode;
    pccr_cmp_mode_t   cmp_mode;
    logic [1:0]       chan_sel;
    logic             edge_pol;
    logic             gate_en;
    logic             sel_level;
    logic             gate_block;
    logic             dom_tick;
    logic             dom_rst;
    logic             apply;
    logic [2:0]       presc_mask;
    logic             slow_fire;
    logic             ev_fire;
    logic             cce_fire;
    logic             match;
    logic [3:0]       ch_rise;
    logic [3:0]       ch_fall;
    logic [CNT_W-1:0] range_hi;
    logic [CNT_W-1:0] range_lo;
    logic             hw_ovf;
    logic             hw_sec_ovf;
    logic [5:0]       hw_flags;

    assign trig_mode  = pccr_trig_mode_t'(ctrl_act[`PCCR_F_MODE_HI:`PCCR_F_MODE_LO]);
    assign cmp_mode   = pccr_cmp_mode_t'(ctrl_act[`PCCR_F_CMP_HI:`PCCR_F_CMP_LO]);
    assign chan_sel   = ctrl_act[`PCCR_F_SEL_HI:`PCCR_F_SEL_LO];
    assign edge_pol   = ctrl_act[`PCCR_F_POL];
    assign gate_en    = ctrl_act[`PCCR_F_GATE];
    assign sel_level  = event_chan_in[chan_sel];
    // Gating stops the counter tick, so pending writes wait as well
    assign gate_block = gate_en & (sel_level == ~edge_pol);
    assign dom_tick   = slow_tick_in & ~gate_block;
    // Hold acts at once from the written bit, release waits for ticks
    assign dom_rst    = ctrl_shadow[`PCCR_F_HOLD] | (rel_cnt != 2'h0);
    assign apply      = dom_tick & ~freeze;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_edge
            assign ch_rise[gi] = event_chan_in[gi] & ~ev_prev[gi];
            assign ch_fall[gi] = ~event_chan_in[gi] & ev_prev[gi];
        end
    endgenerate

    always_comb begin
        case (ctrl_act[`PCCR_F_PRESC_HI:`PCCR_F_PRESC_LO])
            2'h0: presc_mask = 3'h0;
            2'h1: presc_mask = 3'h1;
            2'h2: presc_mask = 3'h3;
            default: presc_mask = 3'h7;
        endcase
    end

    assign slow_fire = (trig_mode == PCCR_TRIG_SLOW) & dom_tick & ~dom_rst
                       & (presc_cnt == presc_mask);
    assign ev_fire   = (trig_mode == PCCR_TRIG_EVENT) & ~dom_rst
                       & (edge_pol ? ch_fall[chan_sel] : ch_rise[chan_sel]);
    assign cce_fire  = slow_fire | ev_fire;

    assign range_hi = {{(CNT_W-8){1'b0}}, limit_val[15:8]};
    assign range_lo = {{(CNT_W-8){1'b0}}, limit_val[7:0]};

    always_comb begin
        case (cmp_mode)
            PCCR_CMP_AT_OR_BELOW: match = (count <= limit_val);
            PCCR_CMP_AT_OR_ABOVE: match = (count >= limit_val);
            PCCR_CMP_RANGE:       match = (count <= range_hi) & (count >= range_lo);
            default:              match = 1'b0;
        endcase
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        next_ctrl_shadow = ctrl_shadow;
        next_ctrl_act    = ctrl_act;
        next_limit_buf   = limit_buf;
        next_limit_val   = limit_val;
        next_count       = count;
        next_sec_count   = sec_count;
        next_sec_wdata   = sec_wdata;
        next_ien         = ien;
        next_route       = route;
        next_insel       = insel;
        next_freeze      = freeze;
        next_pend        = pend;
        next_cmd_stage   = cmd_stage;
        next_rel_cnt     = rel_cnt;
        next_presc_cnt   = presc_cnt;
        next_cce_event   = cce_event_out;
        hw_ovf           = 1'b0;
        hw_sec_ovf       = 1'b0;

        // Applying a pending write clears its bit; a new write re-arms it
        if (apply) begin
            next_pend      = 4'h0;
            next_cmd_stage = 2'h0;
            if (pend[`PCCR_PEND_CTRL]) begin
                next_ctrl_act = ctrl_shadow;
            end
        end

        // Bus writes, decoded at fixed offsets
        if (wr_in) begin
            if (addr_in == `PCCR_OFF_CTRL) begin
                next_ctrl_shadow = wdata_in & `PCCR_CTRL_MASK;
                next_pend[`PCCR_PEND_CTRL] = 1'b1;
            end else if (addr_in == `PCCR_OFF_CMD) begin
                next_cmd_stage = wdata_in[1:0];
                next_pend[`PCCR_PEND_CMD] = 1'b1;
            end else if (addr_in == `PCCR_OFF_LIMIT_BUF) begin
                next_limit_buf = wdata_in[CNT_W-1:0];
                next_pend[`PCCR_PEND_LIMB] = 1'b1;
            end else if (addr_in == `PCCR_OFF_IEN) begin
                next_ien = wdata_in[5:0];
            end else if (addr_in == `PCCR_OFF_ROUTE) begin
                next_route = wdata_in[15:0];
            end else if (addr_in == `PCCR_OFF_FREEZE) begin
                next_freeze = wdata_in[0];
            end else if (addr_in == `PCCR_OFF_SEC_COUNT) begin
                next_sec_wdata = wdata_in[CNT_W-1:0];
                next_pend[`PCCR_PEND_SEC] = 1'b1;
            end else if (addr_in == `PCCR_OFF_INPUT) begin
                next_insel = wdata_in[15:0];
            end
        end

        // Release counter: two counter ticks after the hold bit drops
        if (ctrl_shadow[`PCCR_F_HOLD]) begin
            next_rel_cnt = `PCCR_RELEASE_TICKS;
        end else if (dom_tick && rel_cnt != 2'h0) begin
            next_rel_cnt = rel_cnt - 2'h1;
        end

        if (dom_rst) begin
            next_count     = '0;
            next_sec_count = '0;
            next_limit_val = LIMIT_RESET;
            next_presc_cnt = 3'h0;
            next_cce_event = 1'b0;
        end else begin
            if (trig_mode != PCCR_TRIG_SLOW) begin
                next_presc_cnt = 3'h0;
            end else if (dom_tick) begin
                next_presc_cnt = (presc_cnt == presc_mask) ? 3'h0 : presc_cnt + 3'h1;
            end

            // Compare first, then clear; a count pulse in that cycle is lost
            if (cce_fire) begin
                next_cce_event = match;
                next_count     = '0;
            end else if (apply && pend[`PCCR_PEND_CMD] && cmd_stage[`PCCR_CMD_CLEAR]) begin
                next_count = '0;
            end else if (dom_tick && count_pulse_in) begin
                if (trig_mode != PCCR_TRIG_OFF) begin
                    // With compare-and-clear on, the counter saturates instead of wrapping
                    if (count == {CNT_W{1'b1}}) begin
                        hw_ovf = 1'b1;
                    end else begin
                        next_count = count + CNT_W'(1);
                    end
                end else if (count == limit_val) begin
                    hw_ovf     = 1'b1;
                    next_count = '0;
                end else begin
                    next_count = count + CNT_W'(1);
                end
            end

            if (apply && pend[`PCCR_PEND_SEC]) begin
                next_sec_count = sec_wdata;
            end else if (dom_tick && count_pulse_in) begin
                if (sec_count == limit_val) begin
                    hw_sec_ovf     = 1'b1;
                    next_sec_count = '0;
                end else begin
                    next_sec_count = sec_count + CNT_W'(1);
                end
            end

            if (apply && (pend[`PCCR_PEND_LIMB] ||
                          (pend[`PCCR_PEND_CMD] && cmd_stage[`PCCR_CMD_LOAD]))) begin
                next_limit_val = limit_buf;
            end
        end
    end

    // Hardware set wins over a clear in the same cycle
    always_comb begin
        hw_flags = 6'h00;
        hw_flags[`PCCR_FLAG_OVF]     = hw_ovf;
        hw_flags[`PCCR_FLAG_SEC_OVF] = hw_sec_ovf;
        hw_flags[`PCCR_FLAG_CMP]     = cce_fire & match;
        next_flags = flags;
        if (wr_in && addr_in == `PCCR_OFF_FLAG_CLR) begin
            next_flags = next_flags & ~wdata_in[5:0];
        end
        if (wr_in && addr_in == `PCCR_OFF_FLAG_SET) begin
            next_flags = next_flags | (wdata_in[5:0] & `PCCR_FLAG_MASK);
        end
        next_flags = next_flags | hw_flags;
    end

    // ****************************************
    // Read decode
    // ****************************************
    always_comb begin
        next_rdata = 32'h00000000;
        if (rd_in) begin
            if (addr_in == `PCCR_OFF_CTRL) begin
                next_rdata = ctrl_shadow;
            end else if (addr_in == `PCCR_OFF_STATE) begin
                next_rdata = {31'h00000000, dom_rst};
            end else if (addr_in == `PCCR_OFF_COUNT) begin
                next_rdata = {{(32-CNT_W){1'b0}}, count};
            end else if (addr_in == `PCCR_OFF_LIMIT) begin
                next_rdata = {{(32-CNT_W){1'b0}}, limit_val};
            end else if (addr_in == `PCCR_OFF_LIMIT_BUF) begin
                next_rdata = {{(32-CNT_W){1'b0}}, limit_buf};
            end else if (addr_in == `PCCR_OFF_FLAGS) begin
                next_rdata = {26'h0000000, flags};
            end else if (addr_in == `PCCR_OFF_IEN) begin
                next_rdata = {26'h0000000, ien};
            end else if (addr_in == `PCCR_OFF_ROUTE) begin
                next_rdata = {16'h0000, route};
            end else if (addr_in == `PCCR_OFF_FREEZE) begin
                next_rdata = {31'h00000000, freeze};
            end else if (addr_in == `PCCR_OFF_SYNC) begin
                next_rdata = {28'h0000000, pend};
            end else if (addr_in == `PCCR_OFF_SEC_COUNT) begin
                next_rdata = {{(32-CNT_W){1'b0}}, sec_count};
            end else if (addr_in == `PCCR_OFF_INPUT) begin
                next_rdata = {16'h0000, insel};
            end
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ctrl_shadow   <= `PCCR_CTRL_RESET;
            ctrl_act      <= `PCCR_CTRL_RESET;
            limit_buf     <= LIMIT_RESET;
            limit_val     <= LIMIT_RESET;
            count         <= '0;
            sec_count     <= '0;
            sec_wdata     <= '0;
            flags         <= 6'h00;
            ien           <= 6'h00;
            route         <= 16'h0000;
            insel         <= 16'h0000;
            freeze        <= 1'b0;
            pend          <= 4'h0;
            cmd_stage     <= 2'h0;
            rel_cnt       <= 2'h0;
            presc_cnt     <= 3'h0;
            ev_prev       <= 4'h0;
            cce_event_out <= 1'b0;
            rdata_out     <= 32'h00000000;
        end else begin
            ctrl_shadow   <= next_ctrl_shadow;
            ctrl_act      <= next_ctrl_act;
            limit_buf     <= next_limit_buf;
            limit_val     <= next_limit_val;
            count         <= next_count;
            sec_count     <= next_sec_count;
            sec_wdata     <= next_sec_wdata;
            flags         <= next_flags;
            ien           <= next_ien;
            route         <= next_route;
            insel         <= next_insel;
            freeze        <= next_freeze;
            pend          <= next_pend;
            cmd_stage     <= next_cmd_stage;
            rel_cnt       <= next_rel_cnt;
            presc_cnt     <= next_presc_cnt;
            ev_prev       <= event_chan_in;
            cce_event_out <= next_cce_event;
            rdata_out     <= next_rdata;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rstn_in);

    AST_CMD_READS_ZERO: assert property (
        rd_in && addr_in == `PCCR_OFF_CMD |=> rdata_out == 32'h00000000)
        else $error("command register read not zero");
    AST_FLAG_SET: assert property (
        wr_in && addr_in == `PCCR_OFF_FLAG_SET && wdata_in[0] |=> flags[0])
        else $error("flag set write did not set flag");
    AST_FLAG_CLEAR: assert property (
        wr_in && addr_in == `PCCR_OFF_FLAG_CLR && wdata_in[0] |=> !flags[0])
        else $error("flag clear write did not clear flag");
    AST_LIMIT_READ_ONLY: assert property (
        wr_in && addr_in == `PCCR_OFF_LIMIT && !dom_rst && !apply |=> $stable(limit_val))
        else $error("limit value changed by direct write");
    AST_PEND_RAISED: assert property (
        wr_in && addr_in == `PCCR_OFF_CTRL |=> pend[`PCCR_PEND_CTRL])
        else $error("control write did not raise pending");
    AST_CTRL_APPLIED: assert property (
        apply && pend[`PCCR_PEND_CTRL] |=> ctrl_act == $past(ctrl_shadow) && !pend[0] ||
        $past(wr_in))
        else $error("pending control write not applied on tick");
    AST_GATE_BLOCKS: assert property (
        gate_en && sel_level == ~edge_pol |-> !dom_tick)
        else $error("counter tick passed while gated");
    AST_HOLD_RESET: assert property (
        $fell(ctrl_shadow[`PCCR_F_HOLD]) |-> dom_rst && rel_cnt == 2'h2)
        else $error("domain released too early");
    AST_LE_MATCH: assert property (
        cce_fire && cmp_mode == PCCR_CMP_AT_OR_BELOW && count <= limit_val
        |=> cce_event_out && flags[`PCCR_FLAG_CMP])
        else $error("at-or-below match not reported");
    AST_CLEAR_AFTER: assert property (
        cce_fire |=> count == '0 ##1 cce_event_out == $past(cce_event_out) || $past(cce_fire)
        || dom_rst)
        else $error("counter not cleared after compare");
    AST_PRESC_DIV8: assert property (
        slow_fire && ctrl_act[`PCCR_F_PRESC_HI:`PCCR_F_PRESC_LO] == 2'h3 |-> presc_cnt == 3'h7)
        else $error("prescale eight fired early");
endmodule

// File: dv/pccr_src.sv
`timescale 1ns/10ps
// ************************************
// Pulse source and event channel model
// ************************************
module pccr_src (
    input  wire logic       clk_in,
    input  wire logic       rstn_in,
    input  wire logic       go_in,
    input  wire logic [3:0] n_in,
    input  wire logic       lvl_in,
    input  wire logic [3:0] chan_in,
    output logic            tick_out,
    output logic            pulse_out,
    output logic            busy_out,
    output logic [3:0]      chan_out
);
    logic [3:0] rem;
    logic [1:0] ph;

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rem      <= 4'h0;
            ph       <= 2'h0;
            chan_out <= 4'h0;
        end else begin
            chan_out <= chan_in;
            if (go_in) begin
                rem <= n_in;
                ph  <= 2'h0;
            end else if (tick_out) begin
                rem <= rem - 4'h1;
                ph  <= 2'h0;
            end else if (busy_out) begin
                ph <= ph + 2'h1;
            end
        end
    end

    assign busy_out  = (rem != 4'h0);
    assign tick_out  = busy_out && (ph == 2'h2);
    // Between ticks the count line wanders, so sampling off a tick shows up
    assign pulse_out = tick_out ? lvl_in : ph[0];
endmodule

// File: dv/tb_pulse_counter_compare_clear_regs.sv
`timescale 1ns/10ps
// *********
// Testbench
// *********
module tb_pulse_counter_compare_clear_regs;
    localparam logic [1:0] CM [4] = '{2'h0, 2'h1, 2'h2, 2'h2};
    localparam logic [3:0] KK [4] = '{4'h2, 4'h2, 4'h4, 4'h2};
    localparam logic       EX [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    logic        sys_clk = 1'b0;
    logic        rstn    = 1'b0;
    logic [5:0]  addr    = 6'h00;
    logic [31:0] wdata   = 32'h0;
    logic        wr      = 1'b0;
    logic        rd      = 1'b0;
    logic        go      = 1'b0;
    logic [3:0]  n       = 4'h0;
    logic        lvl     = 1'b0;
    logic [3:0]  chan    = 4'h0;
    logic [31:0] rdata;
    logic        tick, pulse, busy, cce;
    logic [3:0]  echan;
    int          n_errors   = 0;
    int          num_checks = 0;

    always #2.5 sys_clk = ~sys_clk;

    pccr_src i_src (.clk_in(sys_clk), .rstn_in(rstn), .go_in(go), .n_in(n), .lvl_in(lvl),
        .chan_in(chan), .tick_out(tick), .pulse_out(pulse), .busy_out(busy), .chan_out(echan));
    pccr_core i_dut (.sys_clk_in(sys_clk), .rstn_in(rstn), .addr_in(addr), .wdata_in(wdata),
        .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .slow_tick_in(tick),
        .count_pulse_in(pulse), .event_chan_in(echan), .cce_event_out(cce));

    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", w, e, g);
        end
    endtask

    task automatic wr32(input logic [5:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask

    task automatic rc(input logic [5:0] a, input logic [31:0] e, input logic [31:0] m,
                      input string w);
        logic [31:0] d;
        @(posedge sys_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1;
        d = rdata;
        chk(w, e & m, d & m);
    endtask

    // Ticks come only in bursts, so every count below is known exactly
    task automatic burst(input logic [3:0] k, input logic p);
        @(posedge sys_clk);
        n   <= k;
        lvl <= p;
        go  <= 1'b1;
        @(posedge sys_clk);
        go <= 1'b0;
        for (int i = 0; i < 100; i++) begin
            #1;
            if (busy !== 1'b1) break;
            @(posedge sys_clk);
        end
        chk("burst busy", 32'h0, {31'h0, busy});
    endtask

    task automatic set_chan(input logic [3:0] v);
        @(posedge sys_clk);
        chan <= v;
        repeat (3) @(posedge sys_clk);
    endtask

    task automatic t_regs();
        rc(6'h10, 32'hff, '1, "limit");
        rc(6'h14, 32'hff, '1, "limit buffer");
        rc(6'h00, 32'h0, '1, "control");
        rc(6'h34, 32'h0, '1, "unmapped");
        wr32(6'h04, 32'h1);
        rc(6'h04, 32'h0, '1, "command");
        wr32(6'h10, 32'h77);
        wr32(6'h14, 32'h1234);
        wr32(6'h38, 32'h42);
        wr32(6'h00, 32'h02000000);
        rc(6'h10, 32'hff, '1, "limit kept");
        rc(6'h14, 32'h1234, '1, "limit buffer");
        rc(6'h30, 32'hf, 32'hf, "pending");
        rc(6'h00, 32'h02000000, '1, "control");
        burst(4'h1, 1'b0);
        rc(6'h30, 32'h0, 32'hf, "pending");
        rc(6'h10, 32'h1234, '1, "limit applied");
        rc(6'h38, 32'h42, '1, "secondary");
        wr32(6'h2c, 32'h1);
        wr32(6'h04, 32'h2);
        burst(4'h1, 1'b0);
        rc(6'h30, 32'h2, 32'hf, "pending frozen");
        wr32(6'h2c, 32'h0);
        burst(4'h1, 1'b0);
        rc(6'h30, 32'h0, 32'hf, "pending thawed");
    endtask

    task automatic t_flags();
        wr32(6'h1c, 32'h12);
        rc(6'h18, 32'h12, 32'h3f, "flags");
        wr32(6'h1c, 32'h20);
        rc(6'h18, 32'h32, 32'h3f, "flags");
        wr32(6'h20, 32'h02);
        rc(6'h18, 32'h30, 32'h3f, "flags");
        wr32(6'h20, 32'h30);
        rc(6'h18, 32'h0, 32'h3f, "flags");
    endtask

    task automatic t_event();
        logic [3:0] idle;
        for (int i = 0; i < 4; i++) begin
            idle = {4{i[0]}};
            set_chan(idle);
            wr32(6'h00, {1'b0, 2'(i), i[0], 1'b0, CM[i], 5'h0, 2'h2, 18'h0});
            wr32(6'h14, 32'h0503);
            burst(4'h1, 1'b0);
            wr32(6'h04, 32'h1);
            burst(4'h1, 1'b0);
            burst(KK[i], 1'b1);
            rc(6'h0c, 32'(KK[i]), '1, "count");
            set_chan(idle ^ (4'h1 << ((i + 1) % 4)));
            set_chan(idle);
            rc(6'h0c, 32'(KK[i]), '1, "count other channel");
            wr32(6'h20, 32'h3f);
            set_chan(idle ^ (4'h1 << i));
            chk("compare event", {31'h0, EX[i]}, {31'h0, cce});
            rc(6'h18, {26'h0, EX[i], 5'h0}, 32'h20, "compare flag");
            rc(6'h0c, 32'h0, '1, "count cleared");
        end
    endtask

    task automatic t_gate();
        set_chan(4'h0);
        wr32(6'h00, {1'b0, 2'h1, 1'b0, 1'b1, 2'h0, 5'h0, 2'h0, 18'h0});
        burst(4'h1, 1'b0);
        wr32(6'h04, 32'h1);
        burst(4'h1, 1'b0);
        burst(4'h2, 1'b1);
        rc(6'h0c, 32'h2, '1, "count open gate");
        set_chan(4'h2);
        burst(4'h3, 1'b1);
        rc(6'h0c, 32'h2, '1, "count closed gate");
        wr32(6'h38, 32'h7);
        burst(4'h1, 1'b0);
        rc(6'h30, 32'h8, 32'h8, "pending gated");
        set_chan(4'h0);
        burst(4'h1, 1'b0);
        rc(6'h30, 32'h0, 32'h8, "pending open");
        burst(4'h2, 1'b1);
        rc(6'h38, 32'h9, '1, "secondary counted");
    endtask

    task automatic t_hold();
        wr32(6'h00, 32'h20);
        rc(6'h0c, 32'h0, '1, "count in hold");
        rc(6'h10, 32'hff, '1, "limit in hold");
        rc(6'h08, 32'h1, 32'h1, "state in hold");
        wr32(6'h00, 32'h0);
        burst(4'h1, 1'b0);
        rc(6'h08, 32'h1, 32'h1, "state one tick");
        burst(4'h2, 1'b0);
        rc(6'h08, 32'h0, 32'h1, "state released");
    endtask

    task automatic t_slow();
        logic [31:0] d;
        for (int k = 0; k < 4; k++) begin
            wr32(6'h00, {8'h0, 2'(k), 2'h0, 2'h1, 18'h0});
            burst(4'h1, 1'b0);
            wr32(6'h20, 32'h20);
            // Find the prescaler phase before timing one full period
            for (int j = 0; j < 9; j++) begin
                burst(4'h1, 1'b0);
                @(posedge sys_clk);
                addr <= 6'h18;
                rd   <= 1'b1;
                @(posedge sys_clk);
                rd <= 1'b0;
                #1;
                d = rdata;
                if (d[5] === 1'b1) break;
            end
            wr32(6'h20, 32'h20);
            burst(4'((1 << k) - 1), 1'b0);
            rc(6'h18, 32'h0, 32'h20, "flag before period");
            burst(4'h1, 1'b0);
            rc(6'h18, 32'h20, 32'h20, "flag on period");
        end
    endtask

    initial begin
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b1;
        t_regs();
        t_flags();
        t_event();
        t_gate();
        t_hold();
        t_slow();
        end_sim();
    end

    initial begin
        #100us;
        n_errors++;
        end_sim();
    end
endmodule
